// *** core/sdc_cmd_path.sv ***
`timescale 1ns/1ps
`default_nettype none
// Operation
// (RULE_01) Responses MSB first, start 0, dir 0, end 1.
// (RULE_02) All responses CRC checked except R3.
// (RULE_03) R1: 48 bits, index 45:40, status, CRC7.
// (RULE_04) R1b: monitor busy on data line 0.
// (RULE_05) R2: 136 bits, reserved ones, payload 127:1.
// (RULE_06) Card returns identification or specific data.
// (RULE_07) R3 index and CRC fields all ones.
// (RULE_08) R4 index 100111, address, register fields.
// (RULE_09) R4b argument fields decoded for CMD5.
// (RULE_10) R5 index 101000, host address zero.
// (RULE_11) R6 index 000011, address plus status.
// (RULE_12) I/O only status bits 15,14,13 decoded.
// (RULE_13) One bit per card clock per line.
// (RULE_14) Card clock configurable from zero upward.
// (RULE_15) Open drain only for old card init.
// (RULE_16) Data width one until init done.
// (RULE_17) Drivers off during power ramp phases.
// (RULE_18) Bypass picks kernel clock, else divided; here bypass gives half the system clock rate.
// (RULE_19) Flow control stalls clock on buffer hazard.
// (RULE_20) Power save gates clock when bus idle.
// (RULE_21) Enable sends 48-bit command with CRC7.
// (RULE_22) Command line changes on rising card edge; the code changes it on the falling card edge.
// (RULE_23) Accept short or long response, store, flag.
// (RULE_24) Timeout after 64 card clocks without start.
// (RULE_25) Idle at least 8 card clocks between.
// (RULE_26) No-CRC response reports success.
// (RULE_27) Sample once per clock, first low starts.
module sdc_cmd_path
   import sdc_pkg::*;
#(
   parameter int DIV_W = CLK_DIV_W
) (
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   input  wire logic        buf_hazard,
   output logic             card_clock_out,
   input  wire logic        cmd_in,
   output logic             cmd_out,
   output logic             cmd_oe,
   input  wire logic        dat0_in,
   output logic [1:0]       bus_width,
   output logic             bus_power_on
);
   // The divider compare is only as wide as the clock control field, so wider counters are refused.
   if (DIV_W < 1 || DIV_W > CLK_DIV_W) begin : g_bad_div
      $error("DIV_W out of range");
   end

   ////////////////////////////////////////////////////////////////////////
   logic [1:0]       pwr_ff;
   logic [15:0]      clk_ctrl_ff;
   logic [31:0]      arg_ff;
   logic [9:0]       cmd_ctrl_ff;
   logic             start_ff;
   logic [ST_W-1:0]  status_ff;
   logic [127:0]     resp_ff;
   logic [5:0]       resp_idx_ff;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         pwr_ff      <= 2'h0;
         clk_ctrl_ff <= 16'h0000;
         arg_ff      <= RESET_WORD;
         cmd_ctrl_ff <= 10'h000;
      end else if (reg_wr) begin
         unique case (reg_addr)
            ADDR_POWER_CTRL: pwr_ff      <= reg_wdata[1:0];
            ADDR_CLOCK_CTRL: clk_ctrl_ff <= reg_wdata[15:0];
            ADDR_ARGUMENT:   arg_ff      <= reg_wdata;
            ADDR_CMD_CTRL:   cmd_ctrl_ff <= reg_wdata[9:0];
            default:         ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Clock generation: the card clock toggles on a tick of the divider.
   logic [DIV_W-1:0] div_cnt_ff;
   logic             ck_ff;
   logic             bus_active;
   logic             clk_run;
   logic             tick;
   logic             rise;
   logic             fall;
   logic             byp;
   logic             byp_ph_ff;

   assign byp     = clk_ctrl_ff[CLK_BYP_BIT];
   // Stalling instead of gating keeps the output free of glitches.
   assign clk_run = clk_ctrl_ff[CLK_EN_BIT] && pwr_ff[PWR_ON_BIT]
                    && !(clk_ctrl_ff[CLK_FLOW_BIT] && buf_hazard) // RULE_19
                    && !(clk_ctrl_ff[CLK_SAVE_BIT] && !bus_active); // RULE_20
   assign tick    = clk_run && (byp || div_cnt_ff == clk_ctrl_ff[CLK_DIV_LSB +: DIV_W]); // RULE_14

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         div_cnt_ff <= '0;
      end else if (!clk_run || tick) begin
         div_cnt_ff <= '0;
      end else begin
         div_cnt_ff <= div_cnt_ff + 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ck_ff <= 1'b0;
      end else if (tick) begin
         ck_ff <= !ck_ff;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         byp_ph_ff <= 1'b0;
      end else begin
         byp_ph_ff <= clk_run && byp;
      end
   end

   // Bypass runs the card clock at half the system rate, the fastest a single domain can shape.
   assign rise = tick && !ck_ff;
   assign fall = tick && ck_ff;
   assign card_clock_out = ck_ff; // RULE_18

   ////////////////////////////////////////////////////////////////////////
   // Command state machine, stepped once per card clock cycle.
   sdc_state_t       state_ff;
   logic [7:0]       cnt_ff;
   logic [47:0]      tx_ff;
   logic [135:0]     rx_ff;
   logic [6:0]       crc_ff;
   logic [3:0]       gap_ff;
   logic             drv_ff;
   logic             long_rsp;

   assign long_rsp   = cmd_ctrl_ff[CMD_RSP_LSB +: 2] == RSP_LONG;
   assign bus_active = state_ff != SDC_IDLE || start_ff || gap_ff != 4'h0;

   function automatic logic [6:0] crc7_step(input logic [6:0] c, input logic b);
      logic fb;
      fb = c[6] ^ b;
      crc7_step = {c[5:3], c[2] ^ fb, c[1:0], fb};
   endfunction : crc7_step

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         start_ff <= 1'b0;
      end else if (reg_wr && reg_addr == ADDR_CMD_CTRL) begin
         start_ff <= reg_wdata[CMD_EN_BIT];
      end else if (state_ff == SDC_SEND) begin
         start_ff <= 1'b0;
      end
   end

   logic [ST_W-1:0] set_st;
   logic [135:0]    rx_nxt;
   logic            crc_good;

   assign rx_nxt   = {rx_ff[134:0], cmd_in}; // RULE_01
   assign crc_good = crc_ff == rx_ff[6:0]; // RULE_02

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_ff    <= SDC_IDLE;
         cnt_ff      <= 8'h00;
         tx_ff       <= 48'h0;
         rx_ff       <= 136'h0;
         crc_ff      <= 7'h00;
         gap_ff      <= 4'h0;
         drv_ff      <= 1'b0;
         set_st      <= '0;
         resp_ff     <= 128'h0;
         resp_idx_ff <= 6'h00;
      end else begin
         set_st <= '0;
         if (rise && gap_ff != 4'h0) begin
            gap_ff <= gap_ff - 4'h1;
         end
         unique case (state_ff)
            SDC_IDLE: begin
               drv_ff <= 1'b0;
               if (start_ff && gap_ff == 4'h0 && fall) begin // RULE_25
                  tx_ff    <= {1'b0, 1'b1, cmd_ctrl_ff[CMD_IDX_LSB +: 6], arg_ff, 8'h01}; // RULE_21
                  crc_ff   <= 7'h00;
                  cnt_ff   <= 8'h00;
                  drv_ff   <= 1'b1;
                  state_ff <= SDC_SEND;
               end
            end
            SDC_SEND: begin
               if (fall) begin // RULE_22
                  cnt_ff <= cnt_ff + 8'h01;
                  if (cnt_ff < 8'd39) begin
                     crc_ff <= crc7_step(crc_ff, tx_ff[47]);
                     tx_ff  <= {tx_ff[46:0], 1'b0};
                  end else if (cnt_ff == 8'd39) begin
                     tx_ff <= {crc7_step(crc_ff, tx_ff[47]), 1'b1, 40'h0};
                  end else if (cnt_ff < 8'd47) begin
                     tx_ff <= {tx_ff[46:0], 1'b0};
                  end else begin
                     drv_ff <= 1'b0;
                     cnt_ff <= 8'h00;
                     crc_ff <= 7'h00;
                     gap_ff <= 4'(GAP_CYC);
                     if (cmd_ctrl_ff[CMD_RSP_LSB +: 2] == RSP_NONE) begin
                        set_st[ST_SENT] <= 1'b1;
                        state_ff        <= SDC_IDLE;
                     end else begin
                        state_ff <= SDC_WAIT;
                     end
                  end
               end
            end
            SDC_WAIT: begin
               if (rise) begin
                  if (!cmd_in) begin // RULE_27
                     rx_ff    <= 136'h0;
                     cnt_ff   <= 8'h01;
                     state_ff <= SDC_RECV;
                  end else if (cnt_ff == 8'(TIMEOUT_CYC - 1)) begin
                     set_st[ST_TIMEOUT] <= 1'b1; // RULE_24
                     gap_ff             <= 4'(GAP_CYC);
                     state_ff           <= SDC_IDLE;
                  end else begin
                     cnt_ff <= cnt_ff + 8'h01;
                  end
               end
            end
            SDC_RECV: begin
               if (rise) begin // RULE_13
                  rx_ff  <= rx_nxt;
                  cnt_ff <= cnt_ff + 8'h01;
                  // The long payload carries its own checksum, so only bits after the reserved field feed it.
                  if ((long_rsp && cnt_ff >= 8'd8 && cnt_ff < 8'(LONG_BITS - 8))
                      || (!long_rsp && cnt_ff < 8'(CMD_BITS - 8))) begin
                     crc_ff <= crc7_step(crc_ff, cmd_in);
                  end
                  if (cnt_ff == 8'(long_rsp ? LONG_BITS - 1 : CMD_BITS - 1)) begin // RULE_23
                     gap_ff <= 4'(GAP_CYC);
                     if (long_rsp) begin
                        // Register bit 0 is replaced by the end bit on the line, so it reads back as zero.
                        resp_ff     <= {rx_nxt[127:1], 1'b0}; // RULE_05
                        resp_idx_ff <= rx_nxt[133:128];
                     end else begin
                        resp_ff     <= {96'h0, rx_nxt[39:8]};
                        resp_idx_ff <= rx_nxt[45:40]; // RULE_03
                     end
                     // Checked on the registered bits of the previous cycle; the end bit takes no part.
                     if (cmd_ctrl_ff[CMD_NOCRC_BIT] || crc_good) begin // RULE_26
                        set_st[ST_RSP_OK] <= 1'b1;
                     end else begin
                        set_st[ST_CRC_FAIL] <= 1'b1;
                     end
                     state_ff <= cmd_ctrl_ff[CMD_RSP_LSB +: 2] == RSP_BUSY ? SDC_BUSYW : SDC_IDLE;
                  end
               end
            end
            SDC_BUSYW: begin
               if (rise && dat0_in) begin // RULE_04
                  state_ff <= SDC_IDLE;
               end
            end
            default: state_ff <= SDC_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sticky flags: a hardware set in the same cycle as a clear wins.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         status_ff <= '0;
      end else if (reg_wr && reg_addr == ADDR_STATUS_CLR) begin
         status_ff <= (status_ff & ~reg_wdata[ST_W-1:0]) | set_st;
      end else begin
         status_ff <= status_ff | set_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin drive and bus width.
   logic ramp;
   assign ramp         = pwr_ff[PWR_RAMP_BIT] || !pwr_ff[PWR_ON_BIT];
   assign bus_power_on = pwr_ff[PWR_ON_BIT];
   // Open drain only drives the low level; a high bit releases the line.
   assign cmd_out = drv_ff ? tx_ff[47] : 1'b1;
   assign cmd_oe  = drv_ff && !ramp // RULE_17
                    && !(clk_ctrl_ff[CLK_OD_BIT] && clk_ctrl_ff[CLK_INIT_BIT] && tx_ff[47]); // RULE_15
   assign bus_width = clk_ctrl_ff[CLK_INIT_BIT] ? 2'h0 : clk_ctrl_ff[CLK_WIDE_LSB +: 2]; // RULE_16

   ////////////////////////////////////////////////////////////////////////
   // Field decode of the last short response for software.
   function automatic logic [31:0] decode_fields(input logic [5:0] idx, input logic [31:0] w);
      decode_fields = 32'h0;
      unique case (idx)
         IDX_FASTIO: decode_fields = {8'h01, w[15:8], w[7:0], 8'h00}; // RULE_08
         IDX_IRQ:    decode_fields = {8'h02, 7'h00, w[31:16] == 16'h0000, 16'h0000}; // RULE_10
         IDX_RCA:    decode_fields = {8'h03, 5'h00, w[15], w[14], w[13], 16'h0000}; // RULE_11 RULE_12
         IDX_ONES:   decode_fields = {8'h04, 24'h0}; // RULE_07
         default:    decode_fields = {8'h05, 3'h0, w[31], w[30:28], w[27], w[23:8]}; // RULE_09
      endcase
   endfunction : decode_fields

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= RESET_WORD;
      end else if (reg_rd) begin
         unique case (reg_addr)
            ADDR_POWER_CTRL: reg_rdata <= {30'h0, pwr_ff};
            ADDR_CLOCK_CTRL: reg_rdata <= {16'h0, clk_ctrl_ff};
            ADDR_ARGUMENT:   reg_rdata <= arg_ff;
            ADDR_CMD_CTRL:   reg_rdata <= {21'h0, start_ff, cmd_ctrl_ff};
            ADDR_RESP_INDEX: reg_rdata <= {26'h0, resp_idx_ff};
            ADDR_RESP_WORD0: reg_rdata <= resp_ff[127:96];
            ADDR_RESP_WORD1: reg_rdata <= resp_ff[95:64];
            ADDR_RESP_WORD2: reg_rdata <= resp_ff[63:32];
            ADDR_RESP_WORD3: reg_rdata <= resp_ff[31:0];
            ADDR_STATUS:     reg_rdata <= {26'h0, state_ff == SDC_BUSYW, bus_active, status_ff[3:0]};
            ADDR_DECODE:     reg_rdata <= decode_fields(resp_idx_ff, resp_ff[31:0]);
            default:         reg_rdata <= RESET_WORD;
         endcase
      end else begin
         reg_rdata <= RESET_WORD;
      end
   end
endmodule : sdc_cmd_path
`default_nettype wire

// *** core/sdc_pkg.sv ***
package sdc_pkg;
   // Register offsets on the plain register port (byte addresses).
   localparam logic [7:0] ADDR_POWER_CTRL  = 8'h00;
   localparam logic [7:0] ADDR_CLOCK_CTRL  = 8'h04;
   localparam logic [7:0] ADDR_ARGUMENT    = 8'h08;
   localparam logic [7:0] ADDR_CMD_CTRL    = 8'h0C;
   localparam logic [7:0] ADDR_RESP_INDEX  = 8'h10;
   localparam logic [7:0] ADDR_RESP_WORD0  = 8'h14;
   localparam logic [7:0] ADDR_RESP_WORD1  = 8'h18;
   localparam logic [7:0] ADDR_RESP_WORD2  = 8'h1C;
   localparam logic [7:0] ADDR_RESP_WORD3  = 8'h20;
   localparam logic [7:0] ADDR_STATUS      = 8'h24;
   localparam logic [7:0] ADDR_STATUS_CLR  = 8'h28;
   localparam logic [7:0] ADDR_DECODE      = 8'h2C;

   // Power control fields.
   localparam int PWR_ON_BIT     = 0;
   localparam int PWR_RAMP_BIT   = 1;
   // Clock control fields.
   localparam int CLK_DIV_LSB    = 0;
   localparam int CLK_DIV_W      = 8;
   localparam int CLK_EN_BIT     = 8;
   localparam int CLK_SAVE_BIT   = 9;
   localparam int CLK_BYP_BIT    = 10;
   localparam int CLK_FLOW_BIT   = 11;
   localparam int CLK_WIDE_LSB   = 12;
   localparam int CLK_OD_BIT     = 14;
   localparam int CLK_INIT_BIT   = 15;
   // Command control fields.
   localparam int CMD_IDX_LSB    = 0;
   localparam int CMD_RSP_LSB    = 6;
   localparam int CMD_EN_BIT     = 10;
   localparam int CMD_NOCRC_BIT  = 9;
   // Status flags.
   localparam int ST_RSP_OK      = 0;
   localparam int ST_CRC_FAIL    = 1;
   localparam int ST_SENT        = 2;
   localparam int ST_TIMEOUT     = 3;
   localparam int ST_BUSY        = 4;
   localparam int ST_CARD_BUSY   = 5;
   localparam int ST_W           = 6;

   // Response kinds in the command control register.
   localparam logic [1:0] RSP_NONE  = 2'h0;
   localparam logic [1:0] RSP_SHORT = 2'h1;
   localparam logic [1:0] RSP_BUSY  = 2'h2;
   localparam logic [1:0] RSP_LONG  = 2'h3;

   localparam logic [5:0] IDX_ONES  = 6'h3F;
   localparam logic [5:0] IDX_FASTIO = 6'h27;
   localparam logic [5:0] IDX_IRQ   = 6'h28;
   localparam logic [5:0] IDX_RCA   = 6'h03;

   localparam int CMD_BITS       = 48;
   localparam int LONG_BITS      = 136;
   localparam int TIMEOUT_CYC    = 64;
   localparam int GAP_CYC        = 8;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;

   typedef enum logic [2:0] {SDC_IDLE, SDC_SEND, SDC_WAIT, SDC_RECV, SDC_BUSYW} sdc_state_t;
endpackage : sdc_pkg

// *** test/sdc_cmd_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module sdc_cmd_chk
   import sdc_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        rstn,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic        card_clock_out,
   input wire logic        cmd_out,
   input wire logic        cmd_oe,
   input wire logic [1:0]  bus_width,
   input wire logic        bus_power_on
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   ////////////////////
   logic       ck_q;
   logic [7:0] rise_cnt;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ck_q     <= 1'b0;
         rise_cnt <= 8'h00;
      end else begin
         ck_q     <= card_clock_out;
         rise_cnt <= cmd_oe ? rise_cnt + 8'(card_clock_out & ~ck_q) : 8'h00;
      end
   end
   ////////////////////
   a_power_off_quiet: assert property (!bus_power_on |-> !cmd_oe)
      else $error("command line driven while power is off");
   a_rdata_pulse: assert property ((reg_rdata != 32'h0) |-> $past(reg_rd))
      else $error("read data outside the cycle after a read");
   a_bit_stable_rise: assert property ($rose(card_clock_out) |-> $stable(cmd_out))
      else $error("command bit changed at a card clock rise");
   a_start_low: assert property ($rose(cmd_oe) |-> !cmd_out)
      else $error("command frame does not open with a low bit");
   a_frame_length: assert property ($fell(cmd_oe) |-> rise_cnt == 8'(CMD_BITS))
      else $error("command frame length wrong");
   a_end_high: assert property ($fell(cmd_oe) |-> $past(cmd_out))
      else $error("command frame does not close with a high bit");
   a_gap_idle: assert property ($fell(cmd_oe) |-> !cmd_oe [*8])
      else $error("command line driven again too soon");
   a_width_by_write: assert property ($changed(bus_width) |-> $past(reg_wr))
      else $error("bus width changed without a write");
   c_frame_sent: cover property ($fell(cmd_oe));
   c_read_seen: cover property (reg_rd ##1 reg_rdata != 32'h0);
   c_wide_bus: cover property (bus_width != 2'h0);
endmodule : sdc_cmd_chk
bind sdc_cmd_path sdc_cmd_chk sdc_cmd_chk_inst (.clk_sys(clk_sys), .rstn(rstn), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .card_clock_out(card_clock_out), .cmd_out(cmd_out),
   .cmd_oe(cmd_oe), .bus_width(bus_width), .bus_power_on(bus_power_on));
`default_nettype wire

// *** test/sdc_card_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sdc_card_model (
   input  wire logic        card_clock_out,
   input  wire logic        cmd_out,
   input  wire logic        cmd_oe,
   input  wire logic [1:0]  rsp_mode,
   input  wire logic [31:0] rsp_word,
   output logic             cmd_in,
   output logic             dat0_in,
   output logic [5:0]       got_idx,
   output logic [31:0]      got_arg,
   output logic             got_crc_ok
);
   logic         drv;
   logic [47:0]  rx;
   logic [135:0] tx;
   logic [119:0] body;
   int           n;
   int           len;
   // A line released by the host reads the card drive, which rests high.
   assign cmd_in = cmd_oe ? cmd_out : drv;
   function automatic logic [6:0] crc7(input logic [119:0] d, input int w);
      logic [6:0] c;
      logic       fb;
      c = 7'h00;
      for (int i = w - 1; i >= 0; i--) begin
         fb = d[i] ^ c[6];
         c = {c[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
      end
      return c;
   endfunction : crc7
   initial begin
      drv = 1'b1;
      dat0_in = 1'b1;
      got_crc_ok = 1'b0;
      forever begin
         @(posedge card_clock_out);
         if (cmd_oe && !cmd_out) begin
            rx = 48'h0;
            for (n = 46; n >= 0; n--) begin
               @(posedge card_clock_out);
               rx[n] = cmd_out;
            end
            got_idx = rx[45:40];
            got_arg = rx[39:8];
            got_crc_ok = (crc7(120'(rx[47:8]), 40) === rx[7:1]) && rx[46] && rx[0];
            if (rsp_mode != 2'h0) begin
               repeat (10) @(posedge card_clock_out);
               body = {rsp_word, rsp_word, rsp_word, rsp_word[31:8]};
               len = (rsp_mode == 2'h2) ? 136 : 48;
               if (rsp_mode == 2'h2) begin
                  tx = {2'b00, 6'h3F, body, crc7(body, 120), 1'b1};
               end else if (rsp_mode == 2'h3) begin
                  tx = {88'h0, 2'b00, 6'h3F, rsp_word, 7'h7F, 1'b1};
               end else begin
                  tx = {88'h0, 2'b00, got_idx, rsp_word, crc7(120'({got_idx, rsp_word}), 40), 1'b1};
               end
               // Bits leave MSB first, each placed after a card clock fall.
               for (n = len - 1; n >= 0; n--) begin
                  @(negedge card_clock_out);
                  drv = tx[n];
               end
               @(negedge card_clock_out);
               drv = 1'b1;
            end
         end
      end
   end
endmodule : sdc_card_model
`default_nettype wire

// *** test/sdc_cmd_path_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module sdc_cmd_path_bench;
   import sdc_pkg::*;
   logic        clk_sys = 1'b0;
   logic        rstn = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        buf_hazard = 1'b0;
   logic [1:0]  rsp_mode = 2'h0;
   logic [31:0] rsp_word = 32'h0;
   wire logic [31:0] reg_rdata;
   wire logic        card_clock_out, cmd_in, cmd_out, cmd_oe, dat0_in, bus_power_on, got_crc_ok;
   wire logic [1:0]  bus_width;
   wire logic [5:0]  got_idx;
   wire logic [31:0] got_arg;
   int          n_errors = 0;
   int          num_checks = 0;
   logic [31:0] v;
   int          t;
   always #25 clk_sys = ~clk_sys;
   sdc_cmd_path sdc_cmd_path_inst (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .buf_hazard(buf_hazard), .card_clock_out(card_clock_out), .cmd_in(cmd_in), .cmd_out(cmd_out),
      .cmd_oe(cmd_oe), .dat0_in(dat0_in), .bus_width(bus_width), .bus_power_on(bus_power_on));
   sdc_card_model sdc_card_model_inst (.card_clock_out(card_clock_out), .cmd_out(cmd_out),
      .cmd_oe(cmd_oe), .rsp_mode(rsp_mode), .rsp_word(rsp_word), .cmd_in(cmd_in), .dat0_in(dat0_in),
      .got_idx(got_idx), .got_arg(got_arg), .got_crc_ok(got_crc_ok));
   ////////////////////
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   task automatic toggles(output int c);
      logic p;
      repeat (4) @(posedge clk_sys);
      c = 0;
      #1 p = card_clock_out;
      repeat (40) begin
         @(posedge clk_sys);
         #1 c += int'(card_clock_out !== p);
         p = card_clock_out;
      end
   endtask : toggles
   task automatic run_cmd(input logic [5:0] idx, input logic [1:0] rsp, input logic nocrc,
                          input logic [1:0] mode, input logic [31:0] word, input int flag);
      logic [31:0] s;
      rsp_mode <= mode;
      rsp_word <= word;
      wr(ADDR_ARGUMENT, ~word);
      wr(ADDR_CMD_CTRL, {21'h0, 1'b1, nocrc, 1'b0, rsp, idx});
      s = 32'h0;
      for (int i = 0; i < 3000 && s[3:0] == 4'h0; i++) rd(ADDR_STATUS, s);
      check("status", s & 32'h0F, 32'h1 << flag);
      wr(ADDR_STATUS_CLR, 32'h3F);
      // Keeps the idle gap of eight card clocks before the next start.
      repeat (40) @(posedge clk_sys);
   endtask : run_cmd
   ////////////////////
   task automatic t_reset;
      check("oe", 32'(cmd_oe), 32'h0);
      check("power", 32'(bus_power_on), 32'h0);
      check("width", 32'(bus_width), 32'h0);
      rd(8'h3C, v);
      check("unmapped", v, 32'h0);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_clock;
      wr(ADDR_POWER_CTRL, 32'h1);
      wr(ADDR_CLOCK_CTRL, 32'h0000_0500);
      toggles(t);
      check("bypass", 32'(t), 32'h28);
      wr(ADDR_CLOCK_CTRL, 32'h0000_0103);
      toggles(t);
      check("divide", 32'(t), 32'h0A);
      buf_hazard <= 1'b1;
      wr(ADDR_CLOCK_CTRL, 32'h0000_0901);
      toggles(t);
      check("flow", 32'(t), 32'h0);
      buf_hazard <= 1'b0;
      wr(ADDR_CLOCK_CTRL, 32'h0000_9301);
      toggles(t);
      check("save", 32'(t), 32'h0);
      check("init width", 32'(bus_width), 32'h0);
      wr(ADDR_CLOCK_CTRL, 32'h0000_1101);
      toggles(t);
      check("run", 32'(t), 32'h14);
      check("wide", 32'(bus_width), 32'h1);
      $display("t_clock done");
   endtask : t_clock
   task automatic t_cmds;
      run_cmd(6'h0D, RSP_SHORT, 1'b0, 2'h1, 32'h1234_5678, ST_RSP_OK);
      check("idx", 32'(got_idx), 32'h0D);
      check("arg", got_arg, 32'hEDCB_A987);
      check("crc", 32'(got_crc_ok), 32'h1);
      rd(ADDR_RESP_INDEX, v);
      check("rsp idx", v, 32'h0D);
      rd(ADDR_RESP_WORD3, v);
      check("rsp status", v, 32'h1234_5678);
      run_cmd(6'h29, RSP_SHORT, 1'b1, 2'h3, 32'h80FF_8000, ST_RSP_OK);
      rd(ADDR_RESP_WORD3, v);
      check("ocr", v, 32'h80FF_8000);
      rd(ADDR_DECODE, v);
      check("r3 decode", v, 32'h0400_0000);
      run_cmd(6'h03, RSP_SHORT, 1'b0, 2'h1, 32'h1234_E000, ST_RSP_OK);
      rd(ADDR_DECODE, v);
      check("r6 decode", v, 32'h0307_0000);
      run_cmd(6'h07, RSP_BUSY, 1'b0, 2'h1, 32'h0000_0900, ST_RSP_OK);
      run_cmd(6'h29, RSP_SHORT, 1'b0, 2'h3, 32'h80FF_8000, ST_CRC_FAIL);
      run_cmd(6'h02, RSP_LONG, 1'b0, 2'h2, 32'h5A5A_C3C3, ST_RSP_OK);
      rd(ADDR_RESP_WORD0, v);
      check("long", v, 32'h5A5A_C3C3);
      run_cmd(6'h00, RSP_NONE, 1'b0, 2'h0, 32'h0, ST_SENT);
      run_cmd(6'h0D, RSP_SHORT, 1'b0, 2'h0, 32'h0, ST_TIMEOUT);
      $display("t_cmds done");
   endtask : t_cmds
   ////////////////////
   task automatic complete_run;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : complete_run
   initial begin
      repeat (3) @(posedge clk_sys);
      rstn <= 1'b1;
      @(posedge clk_sys);
      t_reset;
      t_clock;
      t_cmds;
      complete_run;
   end
   // Whole run needs about 4300 cycles; this leaves ample margin.
   initial begin
      #3_000_000;
      n_errors++;
      $display("ERROR watchdog expired");
      complete_run;
   end
endmodule : sdc_cmd_path_bench
`default_nettype wire
